// *** include/led_flash_pkg.sv ***
// shared constants and types for the led flash control register bank
package led_flash_pkg;

	// serial slave address and register offsets
	localparam logic [6:0] SLAVE_ADDR     = 7'h53;
	localparam logic [7:0] OFS_GPIO       = 8'h20;
	localparam logic [7:0] OFS_VIN_MON    = 8'h80;
	localparam logic [7:0] OFS_TORCH      = 8'ha0;
	localparam logic [7:0] OFS_FLASH      = 8'hb0;
	localparam logic [7:0] OFS_DURATION   = 8'hc0;
	localparam logic [7:0] OFS_FLAGS      = 8'hd0;
	localparam logic [7:0] OFS_CONFIG_ONE = 8'he0;
	localparam logic [7:0] OFS_CONFIG_TWO = 8'hf0;

	// power-on values
	localparam logic [7:0] RST_GPIO       = 8'h80;
	localparam logic [7:0] RST_VIN_MON    = 8'hf0;
	localparam logic [7:0] RST_TORCH      = 8'h50;
	localparam logic [7:0] RST_FLASH      = 8'h68;
	localparam logic [7:0] RST_DURATION   = 8'h4f;
	localparam logic [7:0] RST_FLAGS      = 8'h40;
	localparam logic [7:0] RST_CONFIG_ONE = 8'h42;
	localparam logic [7:0] RST_CONFIG_TWO = 8'hf0;

	// field positions and widths
	localparam int MODE_LSB      = 0;
	localparam int MODE_W        = 3;
	localparam int ENABLE_W      = 2;
	localparam int TORCH_LSB     = 3;
	localparam int TORCH_W       = 3;
	localparam int IND_LSB       = 6;
	localparam int IND_W         = 2;
	localparam int FLASH_LSB     = 3;
	localparam int FLASH_W       = 4;
	localparam int STROBE_SEL    = 7;
	localparam int TIMEOUT_LSB   = 0;
	localparam int TIMEOUT_W     = 5;
	localparam int LIMIT_LSB     = 5;
	localparam int LIMIT_W       = 2;
	localparam int DUR_FIXED_BIT = 7;
	localparam int FLAG_TIMEOUT  = 0;

	// flash timeout step and clock rate
	localparam int CLK_HZ          = 125_000_000;
	localparam int TIMEOUT_STEP_MS = 32;
	localparam int STEP_CYCLES     = CLK_HZ / 1000 * TIMEOUT_STEP_MS;

	// operating modes held in the shared mode field
	typedef enum logic [2:0] {
		MODE_SHUTDOWN   = 3'b000,
		MODE_INDICATOR  = 3'b001,
		MODE_TORCH      = 3'b010,
		MODE_FLASH      = 3'b011,
		MODE_VOUT       = 3'b100,
		MODE_VOUT_IND   = 3'b101,
		MODE_VOUT_TORCH = 3'b110,
		MODE_VOUT_FLASH = 3'b111
	} mode_t;

	// serial slave sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_REG   = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100
	} i2c_state_t;

	// settings handed to the analog drive
	typedef struct packed {
		mode_t       mode;
		logic        indicator_on;
		logic        torch_on;
		logic        flash_armed;
		logic        flash_on;
		logic        vout_on;
		logic [2:0]  torch_level;
		logic [1:0]  indicator_level;
		logic [3:0]  flash_level;
		logic [1:0]  switch_limit;
		logic [4:0]  timeout_code;
	} led_drive_t;

endpackage

// *** rtl/flash_timer.sv ***
// flash timeout counter in 32 ms steps
module flash_timer #(
	parameter int STEP_CYCLES = led_flash_pkg::STEP_CYCLES
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// control
	input  wire logic       start,
	input  wire logic       abort,
	input  wire logic [4:0] code,
	// status
	output logic            running,
	output logic            expired
);
	import led_flash_pkg::*;

	localparam int CW = $clog2(STEP_CYCLES + 1);
	localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

	logic [CW-1:0] cycle_cnt;
	logic [5:0]    step_cnt;
	logic [5:0]    step_limit;
	logic          step_tick;

	// duration is code plus one steps
	// code plus one
	assign step_limit = {1'b0, code} + 6'h01;
	assign step_tick  = running && (cycle_cnt == STEP_LAST);

	// step divider, restarted on every new pulse
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cycle_cnt <= '0;
		end else if (start || !running || step_tick) begin
			cycle_cnt <= '0;
		end else begin
			cycle_cnt <= cycle_cnt + CW'(1);
		end
	end

	// step counter and end of pulse
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			running  <= 1'b0;
			step_cnt <= 6'h00;
			expired  <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				running  <= 1'b1;
				step_cnt <= 6'h00;
			end else if (abort) begin
				running <= 1'b0;
			end else if (step_tick) begin
				if (step_cnt + 6'h01 == step_limit) begin
					running <= 1'b0;
					expired <= 1'b1;
				end
				step_cnt <= step_cnt + 6'h01;
			end
		end
	end
endmodule

// *** rtl/led_flash_control_registers.sv ***
// register bank of the led flash driver behind its serial slave port

// Contract
// - mode field decodes eight operating modes
// - torch mode write copies into flash
// - flash mode write copies into torch
// - torch bits five to three: level
// - torch bits seven, six: indicator level
// - flash bits six to three: level
// - level strobe: on while high, timeout
// - edge strobe: on for full timeout
// - timeout expiry clears mode enable bits
// - duration bits four to zero: timeout
// - timeout is code plus one times 32ms
// - duration bits six, five: switch limit
// - limit codes one to two-point-five amps
// - duration bit seven reads one after any write (reset value 0x4f leaves it zero)
// - reset loads the listed register values
module led_flash_control_registers #(
	parameter int STEP_CYCLES = led_flash_pkg::STEP_CYCLES
) (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      nrst,
	// serial slave pins
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output logic                           sda_out,
	output logic                           sda_oe,
	// flash trigger pin
	input  wire logic                      strobe_in,
	// drive settings
	output led_flash_pkg::led_drive_t      drive,
	output logic                           timeout_flag
);
	import led_flash_pkg::*;

	logic [2:0]  scl_sync;
	logic [2:0]  sda_sync;
	logic [2:0]  strobe_sync;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic        strobe_rise;
	logic        strobe_lvl;

	i2c_state_t  state;
	logic [3:0]  bit_cnt;
	logic [7:0]  shift;
	logic [7:0]  rd_shift;
	logic [7:0]  rd_byte;
	logic [7:0]  reg_ptr;
	logic        ack_phase;
	logic        rw_read;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        flags_read;

	logic [7:0]  torch;
	logic [7:0]  flash;
	logic [7:0]  duration;
	logic [7:0]  flags;
	logic [7:0]  gpio;
	logic [7:0]  vin_mon;
	logic [7:0]  config_one;
	logic [7:0]  config_two;

	logic        flash_mode;
	logic        flash_start;
	logic        flash_abort;
	logic        flash_running;
	logic        flash_expired;
	logic [2:0]  mode_bits;

	// first stage feeds only the second; edges use stages two and three
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_sync    <= 3'h7;
			sda_sync    <= 3'h7;
			strobe_sync <= 3'h0;
		end else begin
			scl_sync    <= {scl_sync[1:0], scl_in};
			sda_sync    <= {sda_sync[1:0], sda_in};
			strobe_sync <= {strobe_sync[1:0], strobe_in};
		end
	end

	// bus events from the settled samples
	assign scl_rise    = scl_sync[1] && !scl_sync[2];
	assign scl_fall    = !scl_sync[1] && scl_sync[2];
	assign bus_start   = scl_sync[1] && scl_sync[2] && !sda_sync[1] &&
	                     sda_sync[2];
	assign bus_stop    = scl_sync[1] && scl_sync[2] && sda_sync[1] &&
	                     !sda_sync[2];
	assign strobe_lvl  = strobe_sync[1];
	assign strobe_rise = strobe_sync[1] && !strobe_sync[2];

	// open drain: the pin is only ever pulled low
	assign sda_out = 1'b0;

	// register read decode, shared by first and following bytes
	// live register contents
	function automatic logic [7:0] read_mux(input logic [7:0] addr,
		input logic [7:0] t, input logic [7:0] f, input logic [7:0] d,
		input logic [7:0] fl, input logic [7:0] g, input logic [7:0] v,
		input logic [7:0] c1, input logic [7:0] c2);
		logic [7:0] r;
		r = 8'h00;
		unique case (addr)
			OFS_TORCH:      r = t;
			OFS_FLASH:      r = f;
			OFS_DURATION:   r = d;
			OFS_FLAGS:      r = fl;
			OFS_GPIO:       r = g;
			OFS_VIN_MON:    r = v;
			OFS_CONFIG_ONE: r = c1;
			OFS_CONFIG_TWO: r = c2;
			default:        r = 8'h00;
		endcase
		return r;
	endfunction

	// one decode feeds both the first data bit and the shift register
	assign rd_byte = read_mux(reg_ptr, torch, flash, duration, flags, gpio,
		vin_mon, config_one, config_two);

	// slave sequencer: address byte, register byte, data bytes
	// address, register, data order
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			shift      <= 8'h00;
			rd_shift   <= 8'h00;
			reg_ptr    <= 8'h00;
			ack_phase  <= 1'b0;
			rw_read    <= 1'b0;
			sda_oe     <= 1'b0;
			wr_en      <= 1'b0;
			wr_addr    <= 8'h00;
			wr_data    <= 8'h00;
			flags_read <= 1'b0;
		end else begin
			wr_en      <= 1'b0;
			flags_read <= 1'b0;
			if (bus_start) begin
				state     <= ST_ADDR;
				bit_cnt   <= 4'h0;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
			end else if (bus_stop) begin
				state     <= ST_IDLE;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
			end else if (scl_rise && state != ST_IDLE) begin
				if (state == ST_RDATA && ack_phase) begin
					// host not acknowledging ends the read
					ack_phase <= 1'b0;
					bit_cnt   <= 4'h0;
					if (sda_sync[1]) begin
						state <= ST_IDLE;
					end
				end else if (!ack_phase && bit_cnt < 4'h8) begin
					shift   <= {shift[6:0], sda_sync[1]};
					bit_cnt <= bit_cnt + 4'h1;
				end
			end else if (scl_fall) begin
				unique case (state)
					ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					ST_ADDR, ST_REG, ST_WDATA: begin
						if (ack_phase) begin
							// release after the acknowledge clock
							ack_phase <= 1'b0;
							bit_cnt   <= 4'h0;
							sda_oe    <= 1'b0;
							if (state == ST_ADDR && rw_read) begin
								state    <= ST_RDATA;
								rd_shift <= rd_byte << 1;
								sda_oe   <= !rd_byte[7];
								flags_read <= (reg_ptr == OFS_FLAGS);
							end else if (state == ST_ADDR) begin
								state <= ST_REG;
							end else if (state == ST_REG) begin
								reg_ptr <= shift;
								state   <= ST_WDATA;
							end
						end else if (bit_cnt == 4'h8) begin
							if (state != ST_ADDR ||
							    shift[7:1] == SLAVE_ADDR) begin
								ack_phase <= 1'b1;
								sda_oe    <= 1'b1;
								rw_read   <= (state == ST_ADDR) && shift[0];
								if (state == ST_WDATA) begin
									wr_en   <= 1'b1;
									wr_addr <= reg_ptr;
									wr_data <= shift;
								end
							end else begin
								// another slave is addressed
								state <= ST_IDLE;
							end
						end
					end
					ST_RDATA: begin
						if (ack_phase) begin
							sda_oe <= 1'b0;
						end else if (bit_cnt == 4'h0) begin
							rd_shift <= rd_byte << 1;
							sda_oe   <= !rd_byte[7];
							flags_read <= (reg_ptr == OFS_FLAGS);
						end else if (bit_cnt == 4'h8) begin
							sda_oe    <= 1'b0;
							ack_phase <= 1'b1;
						end else begin
							sda_oe   <= !rd_shift[7];
							rd_shift <= {rd_shift[6:0], 1'b0};
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// flash pulse control from the strobe pin and the timer
	assign mode_bits   = torch[MODE_LSB +: MODE_W];
	assign flash_mode  = (mode_bits[ENABLE_W-1:0] == 2'b11);
	assign flash_start = flash_mode && strobe_rise && !flash_running;
	// level mode ends on strobe low
	assign flash_abort = flash_running && (!flash_mode ||
	                     (!flash[STROBE_SEL] && !strobe_lvl));

	flash_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_timer (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.start   (flash_start),
		.abort   (flash_abort),
		.code    (duration[TIMEOUT_LSB +: TIMEOUT_W]),
		.running (flash_running),
		.expired (flash_expired)
	);

	// brightness pair with a shared mode field; host write beats expiry
	// power-on values
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			torch <= RST_TORCH;
			flash <= RST_FLASH;
		end else if (wr_en && wr_addr == OFS_TORCH) begin
			torch <= wr_data;
			flash[MODE_LSB +: MODE_W] <= wr_data[MODE_LSB +: MODE_W];
		end else if (wr_en && wr_addr == OFS_FLASH) begin
			flash <= wr_data;
			torch[MODE_LSB +: MODE_W] <= wr_data[MODE_LSB +: MODE_W];
		end else if (flash_expired) begin
			torch[MODE_LSB +: ENABLE_W] <= 2'b00;
			flash[MODE_LSB +: ENABLE_W] <= 2'b00;
		end
	end

	// duration register; top bit is set by every write whatever is written, zero from reset
	// fixed one
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			duration <= RST_DURATION;
		end else if (wr_en && wr_addr == OFS_DURATION) begin
			duration <= wr_data | (8'h01 << DUR_FIXED_BIT);
		end
	end

	// plain storage registers kept for readback
	// power-on values
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gpio       <= RST_GPIO;
			vin_mon    <= RST_VIN_MON;
			config_one <= RST_CONFIG_ONE;
			config_two <= RST_CONFIG_TWO;
		end else if (wr_en) begin
			if (wr_addr == OFS_GPIO)       gpio       <= wr_data;
			if (wr_addr == OFS_VIN_MON)    vin_mon    <= wr_data;
			if (wr_addr == OFS_CONFIG_ONE) config_one <= wr_data;
			if (wr_addr == OFS_CONFIG_TWO) config_two <= wr_data;
		end
	end

	// flags clear on read; a timeout in the same cycle survives
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			flags <= RST_FLAGS;
		end else begin
			if (flags_read) begin
				flags <= 8'h00;
			end
			if (flash_start) begin
				flags[FLAG_TIMEOUT] <= 1'b0;
			end
			if (flash_expired) begin
				flags[FLAG_TIMEOUT] <= 1'b1;
			end
		end
	end

	// registered decode of the settings for the drive stage
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			drive        <= '0;
			timeout_flag <= 1'b0;
		end else begin
			drive.mode         <= mode_t'(mode_bits);
			drive.vout_on      <= mode_bits[2];
			drive.indicator_on <= (mode_bits[1:0] == 2'b01);
			drive.torch_on     <= (mode_bits[1:0] == 2'b10);
			drive.flash_armed  <= flash_mode;
			drive.flash_on     <= flash_running;
			drive.torch_level     <= torch[TORCH_LSB +: TORCH_W];
			drive.indicator_level <= torch[IND_LSB +: IND_W];
			drive.flash_level     <= flash[FLASH_LSB +: FLASH_W];
			drive.switch_limit    <= duration[LIMIT_LSB +: LIMIT_W];
			drive.timeout_code    <= duration[TIMEOUT_LSB +: TIMEOUT_W];
			timeout_flag          <= flags[FLAG_TIMEOUT];
		end
	end
endmodule

// *** dv/led_flash_checker.sv ***
// port checker for the led flash register bank
module led_flash_checker import led_flash_pkg::*; #(
	parameter int STEP_CYCLES = led_flash_pkg::STEP_CYCLES
) (
	// clock and reset
	input wire logic                      clk_sys,
	input wire logic                      nrst,
	// pins
	input wire logic                      sda_oe,
	input wire logic                      strobe_in,
	// drive settings
	input wire led_flash_pkg::led_drive_t drive,
	input wire logic                      timeout_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	int on_cnt;
	int limit;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// length of the running flash pulse
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			on_cnt <= 0;
		end else begin
			on_cnt <= drive.flash_on ? on_cnt + 1 : 0;
		end
	end
	// code changes mid-pulse are not modelled here
	assign limit = (int'(drive.timeout_code) + 1) * STEP_CYCLES;
	sequence s_armed_rise;
		$rose(strobe_in) && drive.flash_armed && !drive.flash_on;
	endsequence
	sequence s_expiry;
		$rose(timeout_flag) && !drive.flash_on;
	endsequence
	a_ind_decode: assert property (
		drive.indicator_on == (drive.mode[1:0] == 2'b01))
		else $error("indicator decode wrong");
	a_torch_decode: assert property (
		drive.torch_on == (drive.mode[1:0] == 2'b10))
		else $error("torch decode wrong");
	a_vout_decode: assert property (
		drive.vout_on == drive.mode[2])
		else $error("voltage output decode wrong");
	a_flash_armed: assert property (
		$rose(drive.flash_on) |-> drive.flash_armed)
		else $error("flash on without flash mode");
	a_strobe_start: assert property (
		s_armed_rise |-> ##[2:6] drive.flash_on)
		else $error("strobe did not start flash");
	a_expiry_clear: assert property (
		s_expiry |-> drive.mode[1:0] == 2'b00)
		else $error("mode kept after timeout");
	// the length counter has already dropped when the flag shows
	a_expiry_len: assert property (
		s_expiry |-> $past(on_cnt) >= limit)
		else $error("flash timed out early");
	a_pulse_bound: assert property (
		drive.flash_on |-> on_cnt < limit + 4)
		else $error("flash outlived its timeout");
	a_flag_restart: assert property (
		$rose(drive.flash_on) |-> ##[0:2] !timeout_flag)
		else $error("timeout flag kept on new flash");
	a_ack_hold: assert property (
		$rose(sda_oe) |-> sda_oe[*4])
		else $error("acknowledge too short");
endmodule

bind led_flash_control_registers led_flash_checker #(
	.STEP_CYCLES(STEP_CYCLES)
) chk_u (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.sda_oe(sda_oe),
	.strobe_in(strobe_in),
	.drive(drive),
	.timeout_flag(timeout_flag)
);

// *** dv/i2c_host_model.sv ***
// two-wire host model that owns the bus clock
module i2c_host_model import led_flash_pkg::*; (
	// clock
	input  wire logic clk_sys,
	// device pull-down
	input  wire logic sda_oe,
	// wire levels
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic sda_drv;
	// open drain: a released line floats high
	assign sda = sda_drv & ~sda_oe;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// data moves mid-low, sampled mid-high
	task automatic put_bit(input logic b, output logic seen);
		sda_drv = b;
		tick(4);
		scl = 1'b1;
		tick(4);
		seen = sda;
		tick(4);
		scl = 1'b0;
		tick(4);
	endtask
	task automatic start();
		sda_drv = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b0;
		tick(4);
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b1;
		tick(8);
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], s);
		end
		put_bit(1'b1, s);
		ack = (s === 1'b0);
	endtask
	// single byte read, refused afterwards
	task automatic take_byte(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, d[i]);
		end
		put_bit(1'b1, s);
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start();
		send_byte({SLAVE_ADDR, 1'b0}, k0);
		send_byte(a, k1);
		send_byte(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start();
		send_byte({SLAVE_ADDR, 1'b0}, k0);
		send_byte(a, k1);
		start();
		send_byte({SLAVE_ADDR, 1'b1}, k2);
		take_byte(d);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule

// *** dv/led_flash_control_registers_test.sv ***
// self-checking bench for the led flash register bank
module led_flash_control_registers_test;
	timeunit 1ns;
	timeprecision 100ps;
	import led_flash_pkg::*;
	localparam int STEP = 20;
	logic       clk_sys;
	logic       nrst;
	logic       scl;
	logic       sda;
	logic       sda_out;
	logic       sda_oe;
	logic       strobe_in;
	led_drive_t drive;
	logic       timeout_flag;
	int         bad_count;
	int         check_count;

	i2c_host_model host_u (.clk_sys(clk_sys), .sda_oe(sda_oe),
		.scl(scl), .sda(sda));
	led_flash_control_registers #(.STEP_CYCLES(STEP)) dut_u (
		.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .strobe_in(strobe_in),
		.drive(drive), .timeout_flag(timeout_flag));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		host_u.write_reg(a, d, ok);
		check(8'(ok), 8'h01);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		logic [7:0] d;
		logic       ok;
		host_u.read_reg(a, d, ok);
		check(8'(ok), 8'h01);
		check(d, want);
	endtask
	// bounded wait; strobe sync lag is a few cycles
	task automatic wait_flash(input logic level);
		int i;
		i = 0;
		while (drive.flash_on !== level && i < 20) begin
			host_u.tick(1);
			i++;
		end
		if (i == 20) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic pulse_len(output int len);
		len = 0;
		while (drive.flash_on === 1'b1 && len < 400) begin
			host_u.tick(1);
			len++;
		end
		if (len == 400) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic t_reset_values();
		logic [7:0] ofs [8];
		logic [7:0] val [8];
		ofs = '{8'h20, 8'h80, 8'ha0, 8'hb0, 8'hc0, 8'hd0, 8'he0, 8'hf0};
		val = '{8'h80, 8'hf0, 8'h50, 8'h68, 8'h4f, 8'h40, 8'h42, 8'hf0};
		for (int i = 0; i < 8; i++) begin
			rd(ofs[i], val[i]);
		end
		check(8'(sda_out), 8'h00);
		// flags clear on read, unmapped places drop writes
		rd(8'hd0, 8'h00);
		wr(8'h11, 8'h5a);
		rd(8'h11, 8'h00);
		wr(8'hf0, 8'h5a);
		rd(8'hf0, 8'h5a);
	endtask
	task automatic t_mirror();
		wr(8'ha0, 8'hd2);
		rd(8'hb0, 8'h6a);
		wr(8'hb0, 8'h7d);
		rd(8'ha0, 8'hd5);
		check(8'(drive.torch_level), 8'h02);
		check(8'(drive.indicator_level), 8'h03);
		check(8'(drive.flash_level), 8'h0f);
	endtask
	task automatic t_modes();
		logic [2:0] m;
		logic [3:0] got;
		logic [3:0] want;
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			wr(8'ha0, {5'b01010, m});
			got = {drive.vout_on, drive.indicator_on, drive.torch_on,
				drive.flash_armed};
			want = {m[2], m[1:0] == 2'b01, m[1:0] == 2'b10, m[1:0] == 2'b11};
			check(8'(drive.mode), 8'(m));
			check(8'(got), 8'(want));
		end
	endtask
	task automatic t_limits();
		logic [1:0] l;
		for (int i = 0; i < 4; i++) begin
			l = 2'(i);
			wr(8'hc0, {1'b0, l, 5'(i)});
			rd(8'hc0, {1'b1, l, 5'(i)});
			check(8'(drive.switch_limit), 8'(l));
			check(8'(drive.timeout_code), 8'(i));
		end
	endtask
	// code 3 left by t_limits: four steps
	task automatic t_level_flash();
		int len;
		wr(8'hb0, 8'h07);
		strobe_in = 1'b1;
		wait_flash(1'b1);
		host_u.tick(20);
		strobe_in = 1'b0;
		wait_flash(1'b0);
		check(8'(drive.mode), 8'h07);
		check(8'(timeout_flag), 8'h00);
		host_u.tick(8);
		strobe_in = 1'b1;
		wait_flash(1'b1);
		pulse_len(len);
		strobe_in = 1'b0;
		// cleared mode and flag reach the outputs a clock after flash_on
		host_u.tick(2);
		check(8'(len >= 4 * STEP && len <= 4 * STEP + 4), 8'h01);
		check(8'(drive.mode), 8'h04);
		check(8'(timeout_flag), 8'h01);
		rd(8'ha0, 8'h54);
	endtask
	// strobe drops long before the timeout
	task automatic t_edge_flash();
		int len;
		wr(8'hc0, 8'h40);
		wr(8'hb0, 8'h83);
		strobe_in = 1'b1;
		host_u.tick(4);
		strobe_in = 1'b0;
		wait_flash(1'b1);
		host_u.tick(2);
		check(8'(timeout_flag), 8'h00);
		pulse_len(len);
		check(8'(len >= STEP - 2 && len <= STEP + 4), 8'h01);
		rd(8'hb0, 8'h80);
		rd(8'hd0, 8'h01);
		check(8'(timeout_flag), 8'h00);
	endtask
	initial begin
		nrst = 1'b0;
		strobe_in = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (5) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		host_u.tick(4);
		t_reset_values();
		t_mirror();
		t_modes();
		t_limits();
		t_level_flash();
		t_edge_flash();
		conclude();
	end
	// watchdog against a hung transfer
	initial begin
		repeat (100000) @(posedge clk_sys);
		bad_count++;
		conclude();
	end
endmodule
